// ---- inc/rcf_link_if.sv ----
// Byte stream from the framing end to the host parser.
// Assumes both ends share clk; ready may stall the sender at any time.
`timescale 1ns/10ps
interface rcf_link_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    logic last;
    modport dev (output valid, output data, output last, input ready);
    modport host (input valid, input data, input last, output ready);
endinterface

// ---- inc/rcf_pkg.sv ----
// Constants shared by both ends of the remote command response link.
// Assumes a byte-wide valid/ready stream between the two ends.
package rcf_pkg;
    localparam logic [7:0] START_DELIM = 8'h7e;
    localparam logic [7:0] TYPE_RSP = 8'h97;
    localparam logic [7:0] TYPE_REQ = 8'h17;
    localparam logic [15:0] RESERVED_WORD = 16'hfffe;
    localparam logic [7:0] CHK_BASE = 8'hff;
    localparam logic [7:0] ID_NONE = 8'h00;
    // Bytes from frame type through status, before any parameter value
    localparam logic [15:0] FIXED_BODY = 16'h000f;
    localparam logic [15:0] POS_LEN_HI = 16'h0001;
    localparam logic [15:0] POS_LEN_LO = 16'h0002;
    localparam logic [15:0] POS_TYPE = 16'h0003;
    localparam logic [15:0] POS_ID = 16'h0004;
    localparam logic [15:0] POS_ADDR = 16'h0005;
    localparam logic [15:0] POS_RSV = 16'h000d;
    localparam logic [15:0] POS_CMD = 16'h000f;
    localparam logic [15:0] POS_STAT = 16'h0011;
    localparam logic [15:0] POS_PARAM = 16'h0012;
    localparam int MAX_PARAM = 8;
    typedef enum logic [7:0] {
        ST_OK = 8'h00,
        ST_ERROR = 8'h01,
        ST_BAD_CMD = 8'h02,
        ST_BAD_PARAM = 8'h03,
        ST_TX_FAIL = 8'h04,
        ST_CRYPT_ERR = 8'h0c
    } rcf_status_e;
endpackage

// ---- src/rcf_device.sv ----
// Response framer: turns a finished remote command into one response frame.
// Assumes the request fields are held stable while reqValid is high.
`timescale 1ns/10ps

// What this block does
// - Frame opens with start delimiter byte
// - Length counts bytes between length and checksum
// - Type byte marks remote command response
// - Respond only to remote command requests
// - Frame identifier zero suppresses the frame
// - Echo request frame identifier at byte four
// - Responder 64-bit address from byte five
// - Reserved word fixed; host ignores it
// - Two command characters at byte fifteen
// - Status byte carries documented outcome codes
// - Parameter change: no parameter field
// - Query: append current setting after status
// - Checksum is 0xff minus body sum
// - Several frames may share one identifier
module rcf_device #(
    parameter int MAXP = rcf_pkg::MAX_PARAM
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [7:0] reqType,
    input wire logic [7:0] reqFrameId,
    input wire logic [63:0] reqSrcAddr,
    input wire logic [15:0] reqCmd,
    input wire rcf_pkg::rcf_status_e reqStatus,
    input wire logic reqQuery,
    input wire logic [7:0] reqParamLen,
    input wire logic [MAXP-1:0][7:0] reqParam,
    output logic dropPulse,
    rcf_link_if.dev link
);
    import rcf_pkg::*;

    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_SEND = 2'b10
    } rcf_dstate_e;

    typedef struct packed {
        rcf_dstate_e st;
        logic reqReady;
        logic drop;
        logic [7:0] frameId;
        logic [63:0] srcAddr;
        logic [15:0] cmd;
        logic [7:0] status;
        logic [15:0] bodyLen;
        logic [MAXP-1:0][7:0] param;
        logic [15:0] idx;
        logic [7:0] sum;
        logic [1:0] bufValid;
        logic [1:0][7:0] bufData;
        logic [1:0] bufLast;
    } rcf_dev_s;

    rcf_dev_s state_ff;
    rcf_dev_s nxt_state;

    ////////////////////////////////////////////////////////////////////////////
    // Byte at a frame position; the checksum position is handled by the caller
    function automatic logic [7:0] frameByte(input rcf_dev_s s, input logic [15:0] p);
        logic [15:0] off;
        logic [7:0] b;
        off = 16'h0000;
        b = 8'h00;
        if (p == 16'h0000) begin
            b = START_DELIM;
        end else if (p == POS_LEN_HI) begin
            b = s.bodyLen[15:8];
        end else if (p == POS_LEN_LO) begin
            b = s.bodyLen[7:0];
        end else if (p == POS_TYPE) begin
            b = TYPE_RSP;
        end else if (p == POS_ID) begin
            b = s.frameId;
        end else if (p < POS_RSV) begin
            off = p - POS_ADDR;
            b = s.srcAddr[8*(7-off[2:0]) +: 8];
        end else if (p < POS_CMD) begin
            b = (p == POS_RSV) ? RESERVED_WORD[15:8] : RESERVED_WORD[7:0];
        end else if (p < POS_STAT) begin
            b = (p == POS_CMD) ? s.cmd[15:8] : s.cmd[7:0];
        end else if (p == POS_STAT) begin
            b = s.status;
        end else begin
            off = p - POS_PARAM;
            b = s.param[off[$clog2(MAXP+1)-1:0]];
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] lastPos;
    logic [7:0] newByte;
    logic newLast;
    logic push;
    logic pop;
    logic [7:0] clipLen;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.reqReady = 1'b0;
        nxt_state.drop = 1'b0;
        push = 1'b0;
        newByte = 8'h00;
        newLast = 1'b0;
        clipLen = (reqParamLen > 8'(MAXP)) ? 8'(MAXP) : reqParamLen;
        // Checksum sits after the body, so its position is length plus three
        lastPos = state_ff.bodyLen + POS_TYPE;
        // Head entry leaves when the host takes it
        pop = state_ff.bufValid[0] && link.ready;
        if (pop) begin
            nxt_state.bufValid[0] = state_ff.bufValid[1];
            nxt_state.bufData[0] = state_ff.bufData[1];
            nxt_state.bufLast[0] = state_ff.bufLast[1];
            nxt_state.bufValid[1] = 1'b0;
        end
        case (state_ff.st)
            S_IDLE: begin
                if (reqValid && !state_ff.reqReady) begin
                    nxt_state.reqReady = 1'b1;
                    // Only a remote command request with a real identifier earns a reply
                    if (reqType != TYPE_REQ || reqFrameId == ID_NONE) begin
                        nxt_state.drop = 1'b1;
                    end else begin
                        // Each accepted request is one frame; repeats may reuse the id
                        nxt_state.st = S_SEND;
                        nxt_state.frameId = reqFrameId;
                        nxt_state.srcAddr = reqSrcAddr;
                        nxt_state.cmd = reqCmd;
                        nxt_state.status = reqStatus;
                        nxt_state.param = reqParam;
                        // A change carries no value back, a query carries the setting
                        if (reqQuery) begin
                            nxt_state.bodyLen = FIXED_BODY + {8'h00, clipLen};
                        end else begin
                            nxt_state.bodyLen = FIXED_BODY;
                        end
                        nxt_state.idx = 16'h0000;
                        nxt_state.sum = 8'h00;
                    end
                end
            end
            S_SEND: begin
                // Room is judged before the pop so ready never gates the push; through the pop it only picks the slot
                if (!state_ff.bufValid[1]) begin
                    push = 1'b1;
                    if (state_ff.idx == lastPos) begin
                        newByte = CHK_BASE - state_ff.sum;
                        newLast = 1'b1;
                        nxt_state.st = S_IDLE;
                    end else begin
                        newByte = frameByte(state_ff, state_ff.idx);
                        if (state_ff.idx >= POS_TYPE) begin
                            nxt_state.sum = state_ff.sum + newByte;
                        end
                    end
                    nxt_state.idx = state_ff.idx + 16'h0001;
                end
            end
            default: begin
                nxt_state.st = S_IDLE;
            end
        endcase
        if (push) begin
            if (!nxt_state.bufValid[0]) begin
                nxt_state.bufValid[0] = 1'b1;
                nxt_state.bufData[0] = newByte;
                nxt_state.bufLast[0] = newLast;
            end else begin
                nxt_state.bufValid[1] = 1'b1;
                nxt_state.bufData[1] = newByte;
                nxt_state.bufLast[1] = newLast;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= '0;
            state_ff.st <= S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign reqReady = state_ff.reqReady;
    assign dropPulse = state_ff.drop;
    assign link.valid = state_ff.bufValid[0];
    assign link.data = state_ff.bufData[0];
    assign link.last = state_ff.bufLast[0];
endmodule

// ---- src/rcf_host.sv ----
// Host-side parser for remote command response frames.
// Assumes a byte stream that may carry garbage between frames.
`timescale 1ns/10ps
module rcf_host #(
    parameter int MAXP = rcf_pkg::MAX_PARAM
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic rspAck,
    output logic rspValid,
    output logic [7:0] rspFrameId,
    output logic [63:0] rspSrcAddr,
    output logic [15:0] rspCmd,
    output logic [7:0] rspStatus,
    output logic [7:0] rspParamLen,
    output logic [MAXP-1:0][7:0] rspParam,
    output logic badPulse,
    rcf_link_if.host link
);
    import rcf_pkg::*;

    typedef enum logic [4:0] {
        H_HUNT = 5'b00001,
        H_LEN_HI = 5'b00010,
        H_LEN_LO = 5'b00100,
        H_BODY = 5'b01000,
        H_HOLD = 5'b10000
    } rcf_hstate_e;

    typedef struct packed {
        rcf_hstate_e st;
        logic [15:0] len;
        logic [15:0] pos;
        logic [7:0] sum;
        logic typeBad;
        logic valid;
        logic bad;
        logic [7:0] frameId;
        logic [63:0] srcAddr;
        logic [15:0] cmd;
        logic [7:0] status;
        logic [MAXP-1:0][7:0] param;
    } rcf_host_s;

    rcf_host_s state_ff;
    rcf_host_s nxt_state;
    logic take;
    logic [15:0] off;
    logic lenBad;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state = state_ff;
        nxt_state.bad = 1'b0;
        off = state_ff.pos - POS_PARAM;
        lenBad = (state_ff.len < FIXED_BODY) || (state_ff.len > FIXED_BODY + 16'(MAXP));
        take = link.valid && (state_ff.st != H_HOLD);
        case (state_ff.st)
            H_HUNT: begin
                if (take && link.data == START_DELIM) begin
                    nxt_state.st = H_LEN_HI;
                end
            end
            H_LEN_HI: begin
                if (take) begin
                    nxt_state.len[15:8] = link.data;
                    nxt_state.st = H_LEN_LO;
                end
            end
            H_LEN_LO: begin
                if (take) begin
                    nxt_state.len[7:0] = link.data;
                    nxt_state.pos = POS_TYPE;
                    nxt_state.sum = 8'h00;
                    nxt_state.typeBad = 1'b0;
                    nxt_state.st = H_BODY;
                end
            end
            H_BODY: begin
                if (take) begin
                    nxt_state.pos = state_ff.pos + 16'h0001;
                    if (state_ff.pos == state_ff.len + POS_TYPE) begin
                        // Bad sum or impossible length: drop, never deliver
                        if (link.data != CHK_BASE - state_ff.sum || lenBad
                            || state_ff.typeBad) begin
                            nxt_state.bad = 1'b1;
                            nxt_state.st = H_HUNT;
                        end else begin
                            nxt_state.valid = 1'b1;
                            nxt_state.st = H_HOLD;
                        end
                    end else begin
                        nxt_state.sum = state_ff.sum + link.data;
                        if (state_ff.pos == POS_TYPE) begin
                            nxt_state.typeBad = (link.data != TYPE_RSP);
                        end else if (state_ff.pos == POS_ID) begin
                            nxt_state.frameId = link.data;
                        end else if (state_ff.pos < POS_RSV) begin
                            nxt_state.srcAddr = {state_ff.srcAddr[55:0], link.data};
                        end else if (state_ff.pos < POS_CMD) begin
                            // Reserved word is skipped whatever it holds
                            nxt_state.typeBad = state_ff.typeBad;
                        end else if (state_ff.pos < POS_STAT) begin
                            nxt_state.cmd = {state_ff.cmd[7:0], link.data};
                        end else if (state_ff.pos == POS_STAT) begin
                            nxt_state.status = link.data;
                        end else if (off < 16'(MAXP)) begin
                            nxt_state.param[off[$clog2(MAXP+1)-1:0]] = link.data;
                        end
                    end
                end
            end
            H_HOLD: begin
                // Stalls the link until the user takes the frame; same id may recur
                if (rspAck) begin
                    nxt_state.valid = 1'b0;
                    nxt_state.st = H_HUNT;
                end
            end
            default: begin
                nxt_state.st = H_HUNT;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= '0;
            state_ff.st <= H_HUNT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign link.ready = (state_ff.st != H_HOLD);
    assign rspValid = state_ff.valid;
    assign rspFrameId = state_ff.frameId;
    assign rspSrcAddr = state_ff.srcAddr;
    assign rspCmd = state_ff.cmd;
    assign rspStatus = state_ff.status;
    assign rspParamLen = 8'(state_ff.len - FIXED_BODY);
    assign rspParam = state_ff.param;
    assign badPulse = state_ff.bad;
endmodule

// ---- tb/rcf_link_chk.sv ----
// Checker for the response byte stream between the two ends.
// Assumes one clock; sees only the link signals as plain inputs.
`timescale 1ns/10ps
module rcf_link_chk #(
    parameter int MAXP = rcf_pkg::MAX_PARAM
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic valid,
    input wire logic ready,
    input wire logic [7:0] data,
    input wire logic last
);
    import rcf_pkg::*;
    logic [15:0] cnt_ff;
    logic [15:0] len_ff;
    logic [7:0] sum_ff;
    // Byte position, length and running sum rebuilt from the wire alone
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_ff <= 16'h0000;
            len_ff <= 16'h0000;
            sum_ff <= 8'h00;
        end else if (valid && ready) begin
            cnt_ff <= last ? 16'h0000 : cnt_ff + 16'h0001;
            if (cnt_ff == POS_LEN_HI) len_ff[15:8] <= data;
            if (cnt_ff == POS_LEN_LO) len_ff[7:0] <= data;
            sum_ff <= (cnt_ff < POS_TYPE) ? 8'h00 : sum_ff + data;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_start_delim: assert property (
        valid && cnt_ff == 16'h0000 |-> data == START_DELIM)
        else $error("frame does not open with start byte");
    chk_last_place: assert property (
        valid && cnt_ff > POS_TYPE |-> last == (cnt_ff == len_ff + POS_TYPE))
        else $error("frame end does not match length");
    chk_type_byte: assert property (
        valid && cnt_ff == POS_TYPE |-> data == TYPE_RSP)
        else $error("wrong frame type byte");
    chk_id_nonzero: assert property (
        valid && cnt_ff == POS_ID |-> data != ID_NONE)
        else $error("frame sent with zero identifier");
    chk_reserved_word: assert property (
        valid && cnt_ff == POS_RSV |-> data == RESERVED_WORD[15:8])
        else $error("reserved word high byte not fixed");
    chk_reserved_low: assert property (
        valid && cnt_ff == POS_RSV + 16'h0001 |-> data == RESERVED_WORD[7:0])
        else $error("reserved word low byte not fixed");
    chk_len_range: assert property (
        valid && cnt_ff == POS_TYPE |-> len_ff >= FIXED_BODY && len_ff <= FIXED_BODY + MAXP)
        else $error("length outside body range");
    chk_checksum_end: assert property (
        valid && last |-> data == CHK_BASE - sum_ff)
        else $error("bad checksum byte");
    chk_stall_hold: assert property (
        valid && !ready |=> valid && $stable(data) && $stable(last))
        else $error("byte changed while stalled");
    cover property (valid && !ready);
    cover property (valid && last && len_ff > FIXED_BODY);
    cover property (valid && last && len_ff == FIXED_BODY);
endmodule

// ---- tb/remote_command_response_framer_tb.sv ----
// Bench joining both ends, plus a second host fed broken frames.
// Assumes the package constants and one 200 MHz clock.
`timescale 1ns/10ps
module remote_command_response_framer_tb;
    import rcf_pkg::*;
    localparam int MAXP = 8;
    typedef struct packed {
        logic [7:0] id;
        logic [63:0] addr;
        logic [15:0] cmd;
        logic [7:0] st;
        logic [7:0] n;
        logic [MAXP-1:0][7:0] p;
    } rcf_exp_s;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic reqValid, reqReady, reqQuery, dropPulse, rspAck, rspValid, badPulse, bad2, val2, ack2;
    logic [7:0] reqType, reqFrameId, reqParamLen, rspFrameId, rspStatus, rspParamLen;
    logic [63:0] reqSrcAddr, rspSrcAddr;
    logic [15:0] reqCmd, rspCmd;
    logic [MAXP-1:0][7:0] reqParam, rspParam;
    rcf_status_e reqStatus;
    rcf_status_e sts[6] = '{ST_OK, ST_ERROR, ST_BAD_CMD, ST_BAD_PARAM, ST_TX_FAIL, ST_CRYPT_ERR};
    logic [31:0] seed = 32'h000105fd;
    logic [8:0] w;
    logic qv;
    logic [7:0] plv;
    logic [8:0] wq[$];
    logic [7:0] frm[$];
    rcf_exp_s eq[$];
    rcf_exp_s e, ex;
    int err_count = 0, num_checks = 0, cyc = 0, badN = 0, bad2N = 0, val2N = 0, t;
    rcf_link_if lnk();
    rcf_link_if lnk2();
    rcf_device #(.MAXP(MAXP)) rcf_device_inst(.clk, .reset, .reqValid, .reqReady, .reqType,
        .reqFrameId, .reqSrcAddr, .reqCmd, .reqStatus, .reqQuery, .reqParamLen, .reqParam,
        .dropPulse, .link(lnk));
    rcf_host #(.MAXP(MAXP)) rcf_host_inst(.clk, .reset, .rspAck, .rspValid, .rspFrameId,
        .rspSrcAddr, .rspCmd, .rspStatus, .rspParamLen, .rspParam, .badPulse, .link(lnk));
    // Second host only ever sees frames the bench hand-makes: three broken, then one good with swapped reserved bytes
    rcf_host #(.MAXP(MAXP)) rcf_host_inst2(.clk, .reset, .rspAck(ack2), .rspValid(val2),
        .rspFrameId(), .rspSrcAddr(), .rspCmd(), .rspStatus(), .rspParamLen(), .rspParam(),
        .badPulse(bad2), .link(lnk2));
    rcf_link_chk #(.MAXP(MAXP)) rcf_link_chk_inst(.clk, .reset, .valid(lnk.valid),
        .ready(lnk.ready), .data(lnk.data), .last(lnk.last));
    always #2.5 clk = ~clk;
    ////////////////////////////////////////
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task cmp(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task wrap_up();
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Model of one whole frame, start byte through checksum
    function void build(input rcf_exp_s f);
        logic [7:0] s;
        logic [15:0] len;
        s = 8'h00;
        frm = {TYPE_RSP, f.id};
        for (int k = 7; k >= 0; k--) frm.push_back(f.addr[k*8+:8]);
        frm.push_back(8'hff);
        frm.push_back(8'hfe);
        frm.push_back(f.cmd[15:8]);
        frm.push_back(f.cmd[7:0]);
        frm.push_back(f.st);
        for (int k = 0; k < f.n; k++) frm.push_back(f.p[k]);
        foreach (frm[k]) s += frm[k];
        len = 16'(frm.size());
        frm.push_back(8'hff - s);
        frm.push_front(len[7:0]);
        frm.push_front(len[15:8]);
        frm.push_front(8'h7e);
    endfunction
    task req(input logic [7:0] ty, input rcf_status_e st, input logic q, input logic [7:0] pl);
        logic f;
        f = (ty == TYPE_REQ) && (e.id != ID_NONE);
        #1 reqType = ty;
        {reqFrameId, reqSrcAddr, reqCmd} = {e.id, e.addr, e.cmd};
        reqStatus = st;
        {reqQuery, reqParamLen, reqParam, reqValid} = {q, pl, e.p, 1'b1};
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (reqReady !== 1'b1 && t < 300);
        cmp({reqReady, dropPulse}, {1'b1, !f}, "take");
        #1 reqValid = 1'b0;
        if (f) begin
            build(e);
            foreach (frm[k]) wq.push_back({k == frm.size() - 1, frm[k]});
            eq.push_back(e);
        end
        // One edge with the request low, so every input moves at the same offset
        @(posedge clk);
    endtask
    task raw();
        foreach (frm[k]) begin
            #1 {lnk2.valid, lnk2.data, lnk2.last} = {1'b1, frm[k], k == frm.size() - 1};
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (lnk2.ready !== 1'b1 && t < 50);
        end
        #1 lnk2.valid = 1'b0;
        repeat (4) @(posedge clk);
    endtask
    ////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        badN += int'(badPulse === 1'b1);
        bad2N += int'(bad2 === 1'b1);
        val2N += int'(val2 === 1'b1);
        // Ceiling well above the several hundred cycles the run needs
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    always @(posedge clk) begin
        if (reset === 1'b0 && lnk.valid === 1'b1 && lnk.ready === 1'b1) begin
            w = (wq.size() > 0) ? wq.pop_front() : 'x;
            cmp(lnk.data, w[7:0], "wire byte");
            cmp(lnk.last, w[8], "frame end");
        end
    end
    // Slow, random acknowledge keeps the host stalling the sender
    initial forever begin
        @(posedge clk);
        if (rspValid === 1'b1) begin
            ex = eq.size() > 0 ? eq.pop_front() : 'x;
            cmp(rspFrameId, ex.id, "frame id");
            cmp(rspCmd, ex.cmd, "command");
            cmp(rspStatus, ex.st, "status");
            cmp(rspParamLen, ex.n, "param count");
            cmp(rspSrcAddr, ex.addr, "addr");
            for (int k = 0; k < ex.n; k++) cmp(rspParam[k], ex.p[k], "param");
            repeat (rnd() % 5) @(posedge clk);
            #1 rspAck = 1'b1;
            @(posedge clk);
            #1 rspAck = 1'b0;
            @(posedge clk);
        end
    end
    initial begin
        {reqValid, reqType, reqFrameId, reqSrcAddr, reqCmd, reqQuery, reqParamLen} = '0;
        {reqParam, rspAck, ack2, e} = {64'h0, 1'b0, 1'b1, 168'h0};
        reqStatus = ST_OK;
        {lnk2.valid, lnk2.data, lnk2.last} = 10'h000;
        repeat (6) @(posedge clk);
        #1 reset = 1'b0;
        @(posedge clk);
        for (int i = 0; i < 24; i++) begin
            e.id = (i % 5 == 0) ? 8'h00 : (i % 3 == 1) ? e.id : 8'(rnd());
            {e.addr, e.cmd, e.p} = {rnd(), rnd(), 16'(rnd()), rnd(), rnd()};
            e.st = sts[i % 6];
            qv = 1'(rnd());
            plv = 8'(rnd() % 11);
            e.n = qv ? ((plv > MAXP) ? 8'(MAXP) : plv) : 8'h00;
            req((i % 7 == 3) ? 8'h18 : TYPE_REQ, sts[i % 6], qv, plv);
        end
        t = 0;
        while ((eq.size() > 0 || wq.size() > 0) && t < 3000) begin
            @(posedge clk);
            t++;
        end
        cmp(eq.size() + wq.size(), 0, "drain");
        cmp(badN, 0, "main host drop");
        build(e);
        frm[frm.size() - 1] ^= 8'h01;
        raw();
        cmp(bad2N, 1, "bad checksum kept");
        frm = {8'h7e, 8'h00, 8'h05, 8'h97, 8'h01, 8'h02, 8'h03, 8'h04, 8'h5e};
        raw();
        cmp(bad2N, 2, "short length kept");
        build(e);
        // Type one higher and checksum one lower, so only the type is wrong
        frm[3] = 8'h98;
        frm[frm.size() - 1] -= 8'h01;
        raw();
        cmp(bad2N, 3, "wrong type kept");
        build(e);
        // Swapped reserved bytes keep the sum; the host must not care
        {frm[13], frm[14]} = {frm[14], frm[13]};
        raw();
        cmp({bad2N, val2N}, {32'h3, 32'h1}, "good frame");
        wrap_up();
    end
endmodule
